// *** core/vector_map_defines.svh ***
// Constants for the upper maskable vector map and the saved-PC selection.
// Assumes it is included by bare name from the design modules.
`ifndef VECTOR_MAP_DEFINES_SVH
`define VECTOR_MAP_DEFINES_SVH

// ****************************************************************
// Source counts
// ****************************************************************
`define MASK_SOURCES      32
`define FIRST_PRIORITY    23
`define TIMER_LINES       9
`define CLOCKED_CHANNELS  4
`define ASYNC_CHANNELS    3
`define DMA_CHANNELS      4

// ****************************************************************
// Line positions inside the request vector (bit i = priority 23+i)
// ****************************************************************
`define POS_INTERVAL      5'h09
`define POS_CLOCKED_BASE  5'h0A
`define POS_ASYNC_BASE    5'h12
`define POS_CONVERTER     5'h18
`define POS_DMA_BASE      5'h19
`define POS_KEY_RETURN    5'h1D
`define POS_WATCH_INTVL   5'h1E
`define POS_WATCH_REF     5'h1F

// ****************************************************************
// Exception codes and address arithmetic
// ****************************************************************
`define MASK_CODE_BASE    16'h01F0
`define NMI_CODE          16'h0010
`define WDT_CODE          16'h0020
`define ILLEGAL_CODE      16'h0060
`define ILLEGAL_PC_OFFSET 32'h0000_0004
`define HANDLER_UPPER     16'h0000

`endif

// *** core/vector_map_pkg.sv ***
// Types shared by the vector map controller and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package vector_map_pkg;

    // Class of the granted event, selects the save register
    typedef enum logic [1:0] {
        CLASS_MASKABLE,
        CLASS_FATAL,
        CLASS_DEBUG
    } irq_class_t;

    // Kind of instruction in flight when the core accepts
    typedef enum logic [2:0] {
        KIND_PLAIN,
        KIND_SHORT_LOAD,
        KIND_DIVIDE,
        KIND_FRAME_SETUP,
        KIND_FRAME_TEARDOWN
    } instr_kind_t;

    // Grant handshake state
    typedef enum logic {
        ST_IDLE,
        ST_PRESENT
    } grant_state_t;

endpackage : vector_map_pkg

// *** core/fixed_priority_pick.sv ***
// Fixed-priority picker: finds the lowest set line of a request vector.
// Assumes a purely combinational use inside the vector map controller.
`timescale 1ns/1ps
`include "vector_map_defines.svh"

module fixed_priority_pick #(
    parameter int WIDTH = `MASK_SOURCES
) (
    input  wire logic [WIDTH-1:0]         lines,
    output logic                          found,
    output logic [$clog2(WIDTH)-1:0]      index
);

    // ****************************************************************
    // Lowest index wins, matching level 0 as the highest priority
    // ****************************************************************
    function automatic logic [$clog2(WIDTH)-1:0] lowest_set(
        input logic [WIDTH-1:0] vec
    );
        logic [$clog2(WIDTH)-1:0] pick;
        pick = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (vec[i]) begin
                pick = i[$clog2(WIDTH)-1:0];
            end
        end
        return pick;
    endfunction : lowest_set

    // Any pending line and its position
    always_comb begin
        found = |lines;
        index = lowest_set(lines); // see RULE_01
    end

endmodule : fixed_priority_pick

// *** core/restored_pc_select.sv ***
// Chooses the restored PC saved when the core accepts an event.
// Assumes the core reports the interrupted instruction kind and addresses.
`timescale 1ns/1ps
`include "vector_map_defines.svh"

module restored_pc_select (
    input  wire vector_map_pkg::instr_kind_t kind,
    input  wire logic                        sp_updated,
    input  wire logic                        illegal,
    input  wire logic [31:0]                 current_pc,
    input  wire logic [31:0]                 following_instruction_address,
    output logic [31:0]                      restored_pc
);

    // ****************************************************************
    // Abandon-and-restart test
    // ****************************************************************
    function automatic logic restart_needed(
        input vector_map_pkg::instr_kind_t k,
        input logic                        sp_done
    );
        logic r;
        r = 1'b0;
        unique case (k)
            vector_map_pkg::KIND_SHORT_LOAD:     r = 1'b1; // see RULE_09
            vector_map_pkg::KIND_DIVIDE:         r = 1'b1; // see RULE_09
            vector_map_pkg::KIND_FRAME_SETUP:    r = !sp_done; // see RULE_10
            vector_map_pkg::KIND_FRAME_TEARDOWN: r = !sp_done; // see RULE_10
            vector_map_pkg::KIND_PLAIN:          r = 1'b0;
            default:                             r = 1'b0; // Unused kind codes finish normally
        endcase
        return r;
    endfunction : restart_needed

    // Illegal opcode saves offender plus 4; otherwise next or restart
    always_comb begin
        if (illegal) begin
            restored_pc = current_pc + `ILLEGAL_PC_OFFSET; // see RULE_11
        end else if (restart_needed(kind, sp_updated)) begin
            restored_pc = current_pc; // see RULE_09
        end else begin
            restored_pc = following_instruction_address; // see RULE_08
        end
    end

endmodule : restored_pc_select

// *** core/vector_map_ctrl.sv ***
// Vector map controller for maskable priorities 23 to 54 plus the two
// non-maskable sources and the illegal-opcode exception.
// Assumes one-cycle request pulses from peripherals and a core that
// raises accept for one cycle while irq_valid is high.
`timescale 1ns/1ps
`include "vector_map_defines.svh"

// Functional notes
// RULE_01 - Simultaneous maskable requests: lowest default priority number wins, 0 highest.
// RULE_02 - Watchdog overflow beats the external non-maskable pin when simultaneous.
// RULE_03 - Timers three to five at 23-31, codes 01F0-0270; interval timer 32, 0280.
// RULE_04 - Clocked serial 0-3 receive/transmit at 33-40; channel 0 receive shared two-wire 1.
// RULE_05 - Async serial 0-2 at 41-46; shares with clocked 4, two-wire 2 and 0.
// RULE_06 - Converter 47, DMA 48-51, key 52, watch interval 53, watch reference 54.
// RULE_07 - On acceptance, save restored PC into the register of the event class.
// RULE_08 - Normally the saved PC is the following instruction address.
// RULE_09 - Short loads and divides are abandoned; saved PC points back to them.
// RULE_10 - Frame setup/teardown restart only if stack pointer not yet updated.
// RULE_11 - After illegal opcode, saved PC minus 4 is the offending address.
// RULE_12 - Handler address is the exception code zero-extended to 32 bits.
module vector_map_ctrl (
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // Peripheral request pulses
    input  wire logic [`TIMER_LINES-1:0]       timer_request,
    input  wire logic                          interval_timer_zero,
    input  wire logic [`CLOCKED_CHANNELS-1:0]  clocked_serial_rx,
    input  wire logic [`CLOCKED_CHANNELS-1:0]  clocked_serial_tx,
    input  wire logic                          clocked_serial_ch4_rx,
    input  wire logic                          clocked_serial_ch4_tx,
    input  wire logic [2:0]                    two_wire_done,
    input  wire logic [`ASYNC_CHANNELS-1:0]    async_serial_rx,
    input  wire logic [`ASYNC_CHANNELS-1:0]    async_serial_tx,
    input  wire logic                          converter_done_request,
    input  wire logic [`DMA_CHANNELS-1:0]      dma_done,
    input  wire logic                          key_return_request,
    input  wire logic                          watch_interval_request,
    input  wire logic                          watch_reference_request,
    input  wire logic                          nmi_request,
    input  wire logic                          watchdog_overflow_request,
    input  wire logic                          illegal_opcode,
    // Core side
    input  wire logic                          accept,
    input  wire vector_map_pkg::instr_kind_t   kind,
    input  wire logic                          sp_updated,
    input  wire logic [31:0]                   current_pc,
    input  wire logic [31:0]                   following_instruction_address,
    output logic                               irq_valid,
    output logic [15:0]                        irq_code,
    output logic [31:0]                        handler_address,
    output vector_map_pkg::irq_class_t         irq_class,
    output logic [31:0]                        maskable_saved_pc,
    output logic [31:0]                        fatal_saved_pc,
    output logic [31:0]                        debug_saved_pc
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [`MASK_SOURCES-1:0]    lines;
    logic [`MASK_SOURCES-1:0]    pending;
    logic [`MASK_SOURCES-1:0]    clear_mask;
    logic                        nmi_pending;
    logic                        wdt_pending;
    logic                        ilg_pending;
    logic                        pick_found;
    logic [4:0]                  pick_index;
    logic [4:0]                  grant_index;
    logic                        grant_illegal;
    logic                        take;
    logic [31:0]                 restored_pc;
    vector_map_pkg::grant_state_t state;

    // Code of a maskable line: base plus 10H per step
    function automatic logic [15:0] code_of(input logic [4:0] idx);
        return `MASK_CODE_BASE + {7'h00, idx, 4'h0};
    endfunction : code_of

    // ****************************************************************
    // Source-to-line map, shared vectors are ORed
    // ****************************************************************
    always_comb begin
        lines = '0;
        lines[`TIMER_LINES-1:0] = timer_request; // see RULE_03
        lines[`POS_INTERVAL] = interval_timer_zero; // see RULE_03
        for (int c = 0; c < `CLOCKED_CHANNELS; c++) begin
            lines[`POS_CLOCKED_BASE + 2 * c]     = clocked_serial_rx[c]; // see RULE_04
            lines[`POS_CLOCKED_BASE + 2 * c + 1] = clocked_serial_tx[c]; // see RULE_04
        end
        lines[`POS_CLOCKED_BASE] = clocked_serial_rx[0] | two_wire_done[1]; // see RULE_04
        lines[`POS_ASYNC_BASE]     = async_serial_rx[0] | clocked_serial_ch4_rx; // see RULE_05
        lines[`POS_ASYNC_BASE + 1] = async_serial_tx[0] | clocked_serial_ch4_tx; // see RULE_05
        lines[`POS_ASYNC_BASE + 2] = async_serial_rx[1] | two_wire_done[2]; // see RULE_05
        lines[`POS_ASYNC_BASE + 3] = async_serial_tx[1]; // see RULE_05
        lines[`POS_ASYNC_BASE + 4] = async_serial_rx[2] | two_wire_done[0]; // see RULE_05
        lines[`POS_ASYNC_BASE + 5] = async_serial_tx[2]; // see RULE_05
        lines[`POS_CONVERTER] = converter_done_request; // see RULE_06
        for (int d = 0; d < `DMA_CHANNELS; d++) begin
            lines[`POS_DMA_BASE + d] = dma_done[d]; // see RULE_06
        end
        lines[`POS_KEY_RETURN]  = key_return_request; // see RULE_06
        lines[`POS_WATCH_INTVL] = watch_interval_request; // see RULE_06
        lines[`POS_WATCH_REF]   = watch_reference_request; // see RULE_06
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    fixed_priority_pick #(
        .WIDTH (`MASK_SOURCES)
    ) u_pick (
        .lines (pending),
        .found (pick_found),
        .index (pick_index)
    );

    restored_pc_select u_sel (
        .kind                          (kind),
        .sp_updated                    (sp_updated),
        .illegal                       (grant_illegal),
        .current_pc                    (current_pc),
        .following_instruction_address (following_instruction_address),
        .restored_pc                   (restored_pc)
    );

    // Accept only counts while a vector is presented
    assign take = (state == vector_map_pkg::ST_PRESENT) && accept;

    // Pending bit of the granted maskable line drops on acceptance
    always_comb begin
        clear_mask = '0;
        if (take && irq_class == vector_map_pkg::CLASS_MASKABLE) begin
            clear_mask[grant_index] = 1'b1;
        end
    end

    // ****************************************************************
    // Pending latches: a new request wins over a clear
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pending <= '0;
        end else begin
            pending <= (pending & ~clear_mask) | lines;
        end
    end

    // Non-maskable latches; simultaneous pin request is dropped
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wdt_pending <= 1'b0;
            nmi_pending <= 1'b0;
        end else begin
            wdt_pending <= (wdt_pending && !(take && irq_code == `WDT_CODE))
                           || watchdog_overflow_request;
            nmi_pending <= (nmi_pending && !(take && irq_code == `NMI_CODE))
                           || (nmi_request && !watchdog_overflow_request); // see RULE_02
        end
    end

    // Illegal-opcode exception latch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ilg_pending <= 1'b0;
        end else begin
            ilg_pending <= (ilg_pending && !(take && grant_illegal)) || illegal_opcode;
        end
    end

    // ****************************************************************
    // Grant: watchdog, pin, illegal opcode, then maskable by priority
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state           <= vector_map_pkg::ST_IDLE;
            irq_valid       <= 1'b0;
            irq_code        <= 16'h0000;
            handler_address <= 32'h0000_0000;
            irq_class       <= vector_map_pkg::CLASS_MASKABLE;
            grant_index     <= 5'h00;
            grant_illegal   <= 1'b0;
        end else begin
            unique case (state)
                vector_map_pkg::ST_IDLE: begin
                    if (wdt_pending) begin
                        state           <= vector_map_pkg::ST_PRESENT;
                        irq_valid       <= 1'b1;
                        irq_code        <= `WDT_CODE; // see RULE_02
                        handler_address <= {`HANDLER_UPPER, `WDT_CODE}; // see RULE_12
                        irq_class       <= vector_map_pkg::CLASS_FATAL;
                        grant_illegal   <= 1'b0;
                    end else if (nmi_pending) begin
                        state           <= vector_map_pkg::ST_PRESENT;
                        irq_valid       <= 1'b1;
                        irq_code        <= `NMI_CODE;
                        handler_address <= {`HANDLER_UPPER, `NMI_CODE}; // see RULE_12
                        irq_class       <= vector_map_pkg::CLASS_FATAL;
                        grant_illegal   <= 1'b0;
                    end else if (ilg_pending) begin
                        state           <= vector_map_pkg::ST_PRESENT;
                        irq_valid       <= 1'b1;
                        irq_code        <= `ILLEGAL_CODE;
                        handler_address <= {`HANDLER_UPPER, `ILLEGAL_CODE}; // see RULE_12
                        irq_class       <= vector_map_pkg::CLASS_DEBUG;
                        grant_illegal   <= 1'b1;
                    end else if (pick_found) begin
                        state           <= vector_map_pkg::ST_PRESENT;
                        irq_valid       <= 1'b1;
                        irq_code        <= code_of(pick_index); // see RULE_01
                        handler_address <= {`HANDLER_UPPER, code_of(pick_index)}; // see RULE_12
                        irq_class       <= vector_map_pkg::CLASS_MASKABLE;
                        grant_index     <= pick_index;
                        grant_illegal   <= 1'b0;
                    end
                end
                vector_map_pkg::ST_PRESENT: begin
                    if (accept) begin
                        state     <= vector_map_pkg::ST_IDLE;
                        irq_valid <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Save registers, one per event class
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            maskable_saved_pc <= 32'h0000_0000;
            fatal_saved_pc    <= 32'h0000_0000;
            debug_saved_pc    <= 32'h0000_0000;
        end else if (take) begin
            unique case (irq_class)
                vector_map_pkg::CLASS_MASKABLE: maskable_saved_pc <= restored_pc; // see RULE_07
                vector_map_pkg::CLASS_FATAL:    fatal_saved_pc    <= restored_pc; // see RULE_07
                vector_map_pkg::CLASS_DEBUG:    debug_saved_pc    <= restored_pc; // see RULE_07
                default:                        maskable_saved_pc <= maskable_saved_pc;
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_lowest_wins: assert property (@(posedge clk) disable iff (!nrst) // see RULE_01
        (state == vector_map_pkg::ST_IDLE && pick_found && !wdt_pending && !nmi_pending
         && !ilg_pending) |=> (irq_code == code_of($past(pick_index))))
        else $error("maskable grant is not the lowest pending line");

    a_watchdog_first: assert property (@(posedge clk) disable iff (!nrst) // see RULE_02
        (state == vector_map_pkg::ST_IDLE && watchdog_overflow_request && nmi_request)
        |=> ##1 (irq_valid && irq_code == `WDT_CODE))
        else $error("watchdog did not win over the pin request");

    a_timer_codes: assert property (@(posedge clk) disable iff (!nrst) // see RULE_03
        (irq_valid && irq_class == vector_map_pkg::CLASS_MASKABLE && grant_index <= 5'h09)
        |-> (irq_code >= 16'h01F0 && irq_code <= 16'h0280))
        else $error("timer line mapped outside its code range");

    a_clocked_codes: assert property (@(posedge clk) disable iff (!nrst) // see RULE_04
        ($rose(pending[`POS_CLOCKED_BASE])) |-> $past(clocked_serial_rx[0] | two_wire_done[1]))
        else $error("shared clocked serial line latched without a source");

    a_async_codes: assert property (@(posedge clk) disable iff (!nrst) // see RULE_05
        (irq_valid && irq_class == vector_map_pkg::CLASS_MASKABLE && grant_index == 5'h13)
        |-> irq_code == 16'h0320)
        else $error("async serial 0 transmit code wrong");

    a_tail_codes: assert property (@(posedge clk) disable iff (!nrst) // see RULE_06
        (irq_valid && irq_class == vector_map_pkg::CLASS_MASKABLE && grant_index == 5'h1F)
        |-> irq_code == 16'h03E0)
        else $error("watch reference code wrong");

    a_handler_zext: assert property (@(posedge clk) disable iff (!nrst) // see RULE_12
        irq_valid |-> (handler_address == {16'h0000, irq_code}))
        else $error("handler address differs from code");

    a_fatal_save: assert property (@(posedge clk) disable iff (!nrst) // see RULE_07
        (take && irq_class == vector_map_pkg::CLASS_FATAL) |=>
        (fatal_saved_pc == $past(restored_pc) && !irq_valid))
        else $error("fatal save register not loaded");

    a_plain_next: assert property (@(posedge clk) disable iff (!nrst) // see RULE_08
        (take && irq_class == vector_map_pkg::CLASS_MASKABLE
         && kind == vector_map_pkg::KIND_PLAIN)
        |=> maskable_saved_pc == $past(following_instruction_address))
        else $error("plain case did not save the following address");

    a_restart_load: assert property (@(posedge clk) disable iff (!nrst) // see RULE_09
        (take && irq_class == vector_map_pkg::CLASS_MASKABLE
         && (kind == vector_map_pkg::KIND_SHORT_LOAD || kind == vector_map_pkg::KIND_DIVIDE))
        |=> maskable_saved_pc == $past(current_pc))
        else $error("abandoned instruction not restarted");

    a_frame_restart: assert property (@(posedge clk) disable iff (!nrst) // see RULE_10
        (take && irq_class == vector_map_pkg::CLASS_MASKABLE && sp_updated
         && kind == vector_map_pkg::KIND_FRAME_SETUP)
        |=> maskable_saved_pc == $past(following_instruction_address))
        else $error("frame setup restarted after stack update");

    a_illegal_addr: assert property (@(posedge clk) disable iff (!nrst) // see RULE_11
        (take && grant_illegal) |=> (debug_saved_pc - 32'h0000_0004 == $past(current_pc)))
        else $error("illegal opcode save register inconsistent");

endmodule : vector_map_ctrl

// *** bench/core_model.sv ***
// Core stand-in that accepts each presented vector after a set delay.
// Assumes irq_valid from the vector map controller and the same clock.
`timescale 1ns/1ps

module core_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       irq_valid,
    input  wire logic [3:0] delay,
    output logic            accept
);
    logic [3:0] wait_count;

    // One accept pulse per vector, never while nothing is presented
    always @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            accept     <= 1'b0;
            wait_count <= 4'h0;
        end else if (accept || !irq_valid) begin
            accept     <= 1'b0;
            wait_count <= 4'h0;
        end else if (wait_count >= delay) begin
            accept     <= 1'b1;
        end else begin
            wait_count <= wait_count + 4'h1;
        end
    end
endmodule : core_model

// *** bench/interrupt_vector_priority_map_tb.sv ***
// Self-checking bench for the vector map controller.
// Assumes core_model answers the core side; inputs change at falling edges.
`timescale 1ns/1ps

module interrupt_vector_priority_map_tb;
    logic clk, nrst, accept, irq_valid;
    logic [39:0] req;
    logic [3:0]  delay;
    logic [31:0] cur, nxt, handler_address, m_pc, f_pc, d_pc, want;
    logic [15:0] irq_code;
    logic [15:0] rows [37];
    vector_map_pkg::instr_kind_t kind;
    vector_map_pkg::irq_class_t  irq_class;
    logic sp_updated;
    int bad_count, tests_run;

    always #2 clk = ~clk;

    vector_map_ctrl vector_map_ctrl_inst (.clk(clk), .nrst(nrst),
        .timer_request(req[8:0]), .interval_timer_zero(req[9]),
        .clocked_serial_rx({req[16], req[14], req[12], req[10]}),
        .clocked_serial_tx({req[17], req[15], req[13], req[11]}),
        .clocked_serial_ch4_rx(req[32]), .clocked_serial_ch4_tx(req[33]),
        .two_wire_done(req[36:34]), .async_serial_rx({req[22], req[20], req[18]}),
        .async_serial_tx({req[23], req[21], req[19]}), .converter_done_request(req[24]),
        .dma_done(req[28:25]), .key_return_request(req[29]),
        .watch_interval_request(req[30]), .watch_reference_request(req[31]),
        .nmi_request(req[37]), .watchdog_overflow_request(req[38]),
        .illegal_opcode(req[39]), .accept(accept), .kind(kind), .sp_updated(sp_updated),
        .current_pc(cur), .following_instruction_address(nxt), .irq_valid(irq_valid),
        .irq_code(irq_code), .handler_address(handler_address), .irq_class(irq_class),
        .maskable_saved_pc(m_pc), .fatal_saved_pc(f_pc), .debug_saved_pc(d_pc));

    core_model core_model_inst (.clk(clk), .nrst(nrst), .irq_valid(irq_valid),
        .delay(delay), .accept(accept));

    task check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            bad_count++;
            $display("mismatch at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask : check

    task report_and_stop;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // Pulse requests for one cycle
    task pulse(input logic [39:0] v);
        @(negedge clk) req = v;
        @(negedge clk) req = '0;
    endtask : pulse

    // Wait for a vector, compare it, then let the core accept it
    task grant(input logic [15:0] code, input logic [1:0] cls);
        int n;
        n = 0;
        while (irq_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check(irq_code, code);
        check(handler_address, {16'h0000, code});
        check(irq_class, cls);
        while (irq_valid !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask : grant

    initial begin
        #12000;
        bad_count++;
        report_and_stop;
    end

    initial begin
        clk = 0;
        nrst = 0;
        req = '0;
        delay = 0;
        cur = 0;
        nxt = 0;
        sp_updated = 0;
        kind = vector_map_pkg::KIND_PLAIN;
        bad_count = 0;
        tests_run = 0;
        // Row i: request bit i beside its expected code
        for (int i = 0; i < 32; i++) rows[i] = 16'h01F0 + 16'h0010 * i;
        rows[32] = 16'h0310;
        rows[33] = 16'h0320;
        rows[34] = 16'h0350;
        rows[35] = 16'h0290;
        rows[36] = 16'h0330;
        repeat (10) @(negedge clk);
        check(irq_valid, 0);
        check(m_pc, 0);
        $display("test reset done");
        nrst = 1;
        for (int i = 0; i < 37; i++) begin
            delay = 4'(i % 3);
            nxt = 32'h0000_1000 + 4 * i;
            pulse(40'h1 << i);
            grant(rows[i], 2'h0);
            check(m_pc, 32'h0000_1000 + 4 * i);
        end
        $display("test vector table done");
        pulse(40'h0_8010_0020);
        grant(16'h0240, 2'h0);
        grant(16'h0330, 2'h0);
        grant(16'h03E0, 2'h0);
        $display("test simultaneous maskable done");
        pulse(40'h60_0000_0000);
        grant(16'h0020, 2'h1);
        repeat (6) @(negedge clk);
        check(irq_valid, 0);
        nxt = 32'h0000_3000;
        pulse(40'h20_0000_0000);
        grant(16'h0010, 2'h1);
        check(f_pc, 32'h0000_3000);
        cur = 32'h0000_2000;
        pulse(40'h80_0000_0000);
        grant(16'h0060, 2'h2);
        check(d_pc - 32'h0000_0004, cur);
        $display("test non-maskable and illegal done");
        for (int k = 0; k < 10; k++) begin
            kind = vector_map_pkg::instr_kind_t'(k / 2);
            sp_updated = k[0];
            cur = 32'h0000_4000 + 8 * k;
            nxt = cur + 32'h0000_0004;
            pulse(40'h1);
            grant(16'h01F0, 2'h0);
            want = (k / 2 == 1 || k / 2 == 2 || (k / 2 > 2 && !k[0])) ? cur : nxt;
            check(m_pc, want);
        end
        $display("test restored pc kinds done");
        // Reset while a request is pending drops it and clears the maskable and debug save registers
        pulse(40'h1);
        nrst = 0;
        @(negedge clk);
        check(irq_valid, 0);
        nrst = 1;
        repeat (4) @(negedge clk);
        check(irq_valid, 0);
        check(m_pc, 0);
        check(d_pc, 0);
        $display("test mid-run reset done");
        report_and_stop;
    end
endmodule : interrupt_vector_priority_map_tb
